/* src/acs_cfg_regs.sv */
`default_nettype none
module acs_cfg_regs (
    // core clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    // sequence read port
    input wire logic [7:0] seq_rd_idx,
    output logic [3:0] seq_rd_chan,
    // configuration to the converter
    output logic [4:0] repeat_result_count,
    output logic pd_full,
    output logic pd_partial,
    output logic [3:0] scan_mode,
    output logic [3:0] channel_number_field,
    output logic [15:0] channel_scan_mask,
    output logic [15:0] active_chan_mask,
    output logic [7:0] pair_bipolar,
    output logic [7:0] pair_full_span,
    output logic pdiff_common,
    output logic [8:0] sequence_length
);
    // ------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------
    // frame state clears while select is high, so nothing relies
    // on an sclk edge outside a frame
    logic frame_rst_n;
    logic [10:0] bit_cnt_r, bit_cnt_nxt;
    logic [15:0] shift_r, shift_nxt;
    logic in_pat_r, in_pat_nxt;
    logic expect_pat_r, expect_pat_nxt;
    logic [15:0] word_hold_r, word_hold_nxt;
    logic word_tgl_r, word_tgl_nxt;
    logic [3:0] nib_hold_r, nib_hold_nxt;
    logic [7:0] nib_idx_r, nib_idx_nxt;
    logic nib_tgl_r, nib_tgl_nxt;
    logic [15:0] echo_sh_r, echo_sh_nxt;
    logic echo_s1_r, echo_s2_r;
    // echo enable lives in the core domain but is read here first
    logic echo_r, echo_nxt;
    logic pat_now, word_done, nib_done;
    logic [15:0] word_now;

    assign frame_rst_n = nrst && !cs_n;

    always_comb begin
        pat_now = (bit_cnt_r == 11'h000) ? expect_pat_r : in_pat_r;
        word_now = {shift_r[14:0], din};
        word_done = !pat_now && (bit_cnt_r == acs_pkg::BIT_WORD_LAST);
        nib_done = pat_now && (bit_cnt_r[1:0] == 2'b11) && !bit_cnt_r[10];
        bit_cnt_nxt = (bit_cnt_r == acs_pkg::BIT_CNT_MAX) ? bit_cnt_r : bit_cnt_r + 11'h001;
        shift_nxt = word_now;
        in_pat_nxt = pat_now;
        expect_pat_nxt = (bit_cnt_r == 11'h000) ? 1'b0 : expect_pat_r;
        word_hold_nxt = word_hold_r;
        word_tgl_nxt = word_tgl_r;
        nib_hold_nxt = nib_hold_r;
        nib_idx_nxt = nib_idx_r;
        nib_tgl_nxt = nib_tgl_r;
        echo_sh_nxt = {echo_sh_r[14:0], 1'b0};
        if (word_done) begin
            word_hold_nxt = word_now;
            word_tgl_nxt = !word_tgl_r;
            echo_sh_nxt = echo_s2_r ? word_now : 16'h0000;
            if (word_now[acs_pkg::SEL_MSB:acs_pkg::SEL_LSB] == acs_pkg::SEL_SEQ_LEN) begin
                expect_pat_nxt = 1'b1;
            end
        end
        if (nib_done) begin
            nib_hold_nxt = word_now[3:0];
            nib_idx_nxt = bit_cnt_r[9:2];
            nib_tgl_nxt = !nib_tgl_r;
        end
    end

    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt_r <= 11'h000;
            shift_r <= 16'h0000;
            in_pat_r <= 1'b0;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            in_pat_r <= in_pat_nxt;
        end
    end

    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            expect_pat_r <= 1'b0;
            word_hold_r <= 16'h0000;
            word_tgl_r <= 1'b0;
            nib_hold_r <= 4'h0;
            nib_idx_r <= 8'h00;
            nib_tgl_r <= 1'b0;
            echo_sh_r <= 16'h0000;
            echo_s1_r <= 1'b0;
            echo_s2_r <= 1'b0;
        end else begin
            expect_pat_r <= expect_pat_nxt;
            word_hold_r <= word_hold_nxt;
            word_tgl_r <= word_tgl_nxt;
            nib_hold_r <= nib_hold_nxt;
            nib_idx_r <= nib_idx_nxt;
            nib_tgl_r <= nib_tgl_nxt;
            echo_sh_r <= echo_sh_nxt;
            echo_s1_r <= echo_r;
            echo_s2_r <= echo_s1_r;
        end
    end

    assign dout = echo_sh_r[15];

    // ------------------------------------------------------------
    // crossings into the core domain
    // ------------------------------------------------------------
    // held words stay put for a whole word time, far longer than
    // the three core cycles the toggle needs
    logic cs_s1_r, cs_s2_r, cs_s3_r;
    logic wt_s1_r, wt_s2_r, wt_s3_r;
    logic nt_s1_r, nt_s2_r, nt_s3_r;
    logic cs_fall, word_evt, nib_evt;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
            wt_s1_r <= 1'b0;
            wt_s2_r <= 1'b0;
            wt_s3_r <= 1'b0;
            nt_s1_r <= 1'b0;
            nt_s2_r <= 1'b0;
            nt_s3_r <= 1'b0;
        end else begin
            cs_s1_r <= cs_n;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
            wt_s1_r <= word_tgl_r;
            wt_s2_r <= wt_s1_r;
            wt_s3_r <= wt_s2_r;
            nt_s1_r <= nib_tgl_r;
            nt_s2_r <= nt_s1_r;
            nt_s3_r <= nt_s2_r;
        end
    end

    assign cs_fall = cs_s3_r && !cs_s2_r;
    assign word_evt = wt_s2_r ^ wt_s3_r;
    assign nib_evt = nt_s2_r ^ nt_s3_r;

    // ------------------------------------------------------------
    // core registers
    // ------------------------------------------------------------
    logic [1:0] count_r, count_nxt;
    acs_pkg::acs_pd_t pd_r, pd_nxt;
    logic [7:0] range_r, range_nxt, uni_r, uni_nxt, bip_r, bip_nxt;
    logic pdiff_r, pdiff_nxt;
    acs_pkg::acs_mode_t mode_r, mode_nxt;
    logic [3:0] chan_r, chan_nxt;
    logic [15:0] mask_r, mask_nxt;
    acs_pkg::acs_seq_t seq_r, seq_nxt;
    logic [8:0] pend_len_r, pend_len_nxt, wr_cnt_r, wr_cnt_nxt;
    logic [8:0] act_len_r, act_len_nxt, act_cnt_r, act_cnt_nxt;
    logic [4:0] results_r, results_nxt;
    logic pd_full_r, pd_full_nxt, pd_part_r, pd_part_nxt;
    logic [15:0] act_mask_r, act_mask_nxt;
    logic [7:0] bipolar_r, bipolar_nxt, span_r, span_nxt;
    logic [4:0] sel;
    logic mem_wr;

    assign sel = word_hold_r[acs_pkg::SEL_MSB:acs_pkg::SEL_LSB];

    always_comb begin
        count_nxt = count_r;
        pd_nxt = pd_r;
        echo_nxt = echo_r;
        range_nxt = range_r;
        uni_nxt = uni_r;
        bip_nxt = bip_r;
        pdiff_nxt = pdiff_r;
        mode_nxt = mode_r;
        chan_nxt = chan_r;
        mask_nxt = mask_r;
        seq_nxt = seq_r;
        pend_len_nxt = pend_len_r;
        wr_cnt_nxt = wr_cnt_r;
        act_len_nxt = act_len_r;
        act_cnt_nxt = act_cnt_r;
        mem_wr = 1'b0;
        if (word_evt) begin
            case (sel)
                acs_pkg::SEL_CONFIG: begin
                    count_nxt = word_hold_r[acs_pkg::CNT_MSB:acs_pkg::CNT_LSB];
                    pd_nxt = acs_pkg::acs_pd_t'(word_hold_r[acs_pkg::PD_MSB:acs_pkg::PD_LSB]);
                    echo_nxt = word_hold_r[acs_pkg::ECHO_BIT];
                end
                acs_pkg::SEL_RANGE: begin
                    range_nxt = word_hold_r[acs_pkg::PAIR_MSB:acs_pkg::PAIR_LSB];
                end
                acs_pkg::SEL_UNIPOLAR: begin
                    uni_nxt = word_hold_r[acs_pkg::PAIR_MSB:acs_pkg::PAIR_LSB];
                    pdiff_nxt = word_hold_r[acs_pkg::PDIFF_BIT];
                end
                acs_pkg::SEL_BIPOLAR: begin
                    bip_nxt = word_hold_r[acs_pkg::PAIR_MSB:acs_pkg::PAIR_LSB];
                end
                acs_pkg::SEL_SCAN_CTRL: begin
                    mode_nxt = acs_pkg::acs_mode_t'(word_hold_r[acs_pkg::MODE_MSB:acs_pkg::MODE_LSB]);
                    chan_nxt = word_hold_r[acs_pkg::CHAN_MSB:acs_pkg::CHAN_LSB];
                end
                acs_pkg::SEL_CUSTOM_HI: begin
                    mask_nxt[15:8] = word_hold_r[acs_pkg::PAIR_MSB:acs_pkg::PAIR_LSB];
                end
                acs_pkg::SEL_CUSTOM_LO: begin
                    mask_nxt[7:0] = word_hold_r[acs_pkg::PAIR_MSB:acs_pkg::PAIR_LSB];
                end
                acs_pkg::SEL_SEQ_LEN: begin
                    pend_len_nxt = {1'b0, word_hold_r[acs_pkg::PAIR_MSB:acs_pkg::PAIR_LSB]} + 9'h001;
                    seq_nxt = acs_pkg::seq_wait_pattern;
                end
                default: begin
                end
            endcase
        end
        // the pattern overwrites the live table; a conversion running
        // during the pattern frame may see a mix of old and new
        case (seq_r)
            acs_pkg::seq_wait_pattern: begin
                if (cs_fall) begin
                    wr_cnt_nxt = 9'h000;
                    seq_nxt = acs_pkg::seq_in_pattern;
                end
            end
            acs_pkg::seq_in_pattern: begin
                if (nib_evt && ({1'b0, nib_idx_r} < pend_len_r)) begin
                    mem_wr = 1'b1;
                    wr_cnt_nxt = {1'b0, nib_idx_r} + 9'h001;
                end
                if (cs_fall) begin
                    act_len_nxt = pend_len_r;
                    act_cnt_nxt = wr_cnt_r;
                    seq_nxt = acs_pkg::seq_idle;
                end
            end
            default: begin
            end
        endcase
        results_nxt = acs_pkg::RESULT_ONE;
        if (mode_r == acs_pkg::mode_repeat) begin
            results_nxt = 5'(({3'h0, count_r} + 5'h01) << 2);
        end
        pd_full_nxt = (pd_r == acs_pkg::pd_full);
        pd_part_nxt = (pd_r == acs_pkg::pd_partial);
        bipolar_nxt = bip_r & ~uni_r & {8{!pdiff_r}};
        span_nxt = range_r & bipolar_nxt;
        for (int i = 0; i < 16; i++) begin
            case (mode_r)
                acs_pkg::mode_manual, acs_pkg::mode_repeat: act_mask_nxt[i] = (4'(i) == chan_r);
                acs_pkg::mode_standard_int, acs_pkg::mode_standard_scan_external_clock:
                    act_mask_nxt[i] = (4'(i) <= chan_r);
                acs_pkg::mode_upper_int, acs_pkg::mode_upper_ext: act_mask_nxt[i] = (4'(i) >= chan_r);
                acs_pkg::mode_custom_int, acs_pkg::mode_custom_scan_external_clock: act_mask_nxt[i] = mask_r[i];
                default: act_mask_nxt[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count_r <= acs_pkg::COUNT_RESET;
            pd_r <= acs_pkg::pd_normal;
            echo_r <= 1'b0;
            range_r <= acs_pkg::PAIR_RESET;
            uni_r <= acs_pkg::PAIR_RESET;
            bip_r <= acs_pkg::PAIR_RESET;
            pdiff_r <= 1'b0;
            mode_r <= acs_pkg::mode_manual;
            chan_r <= acs_pkg::CHAN_RESET;
            mask_r <= acs_pkg::MASK_RESET;
            seq_r <= acs_pkg::seq_idle;
            pend_len_r <= acs_pkg::LEN_RESET;
            wr_cnt_r <= acs_pkg::LEN_RESET;
            act_len_r <= acs_pkg::LEN_RESET;
            act_cnt_r <= acs_pkg::LEN_RESET;
            results_r <= acs_pkg::RESULT_ONE;
            pd_full_r <= 1'b0;
            pd_part_r <= 1'b0;
            act_mask_r <= acs_pkg::MASK_RESET;
            bipolar_r <= acs_pkg::PAIR_RESET;
            span_r <= acs_pkg::PAIR_RESET;
        end else begin
            count_r <= count_nxt;
            pd_r <= pd_nxt;
            echo_r <= echo_nxt;
            range_r <= range_nxt;
            uni_r <= uni_nxt;
            bip_r <= bip_nxt;
            pdiff_r <= pdiff_nxt;
            mode_r <= mode_nxt;
            chan_r <= chan_nxt;
            mask_r <= mask_nxt;
            seq_r <= seq_nxt;
            pend_len_r <= pend_len_nxt;
            wr_cnt_r <= wr_cnt_nxt;
            act_len_r <= act_len_nxt;
            act_cnt_r <= act_cnt_nxt;
            results_r <= results_nxt;
            pd_full_r <= pd_full_nxt;
            pd_part_r <= pd_part_nxt;
            act_mask_r <= act_mask_nxt;
            bipolar_r <= bipolar_nxt;
            span_r <= span_nxt;
        end
    end

    acs_seq_mem u_seq_mem (
        .core_clk(core_clk),
        .nrst(nrst),
        .wr_en(mem_wr),
        .wr_addr(nib_idx_r),
        .wr_data(nib_hold_r),
        .rd_addr(seq_rd_idx),
        .rd_zero({1'b0, seq_rd_idx} >= act_cnt_r),
        .rd_data_r(seq_rd_chan)
    );

    assign repeat_result_count = results_r;
    assign pd_full = pd_full_r;
    assign pd_partial = pd_part_r;
    assign scan_mode = mode_r;
    assign channel_number_field = chan_r;
    assign channel_scan_mask = mask_r;
    assign active_chan_mask = act_mask_r;
    assign pair_bipolar = bipolar_r;
    assign pair_full_span = span_r;
    assign pdiff_common = pdiff_r;
    assign sequence_length = act_len_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_result_count: assert property (@(posedge core_clk) disable iff (!nrst)
        (mode_r == acs_pkg::mode_repeat) && $stable(count_r) |=> results_r == 5'(($past(count_r) + 3'h1) * 4))
        else $error("repeat result count wrong");
    chk_nonrepeat_one: assert property (@(posedge core_clk) disable iff (!nrst)
        (mode_r != acs_pkg::mode_repeat) |=> results_r == acs_pkg::RESULT_ONE)
        else $error("result count outside repeat mode");
    chk_pd_decode: assert property (@(posedge core_clk) disable iff (!nrst)
        ##1 (pd_full_r == ($past(pd_r) == acs_pkg::pd_full)) && (pd_part_r == ($past(pd_r) == acs_pkg::pd_partial)))
        else $error("power-down decode wrong");
    chk_cfg_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        (pd_r != acs_pkg::pd_normal) && !word_evt |=> $stable(range_r) && $stable(mode_r) && $stable(count_r))
        else $error("register changed in shutdown");
    chk_range_write: assert property (@(posedge core_clk) disable iff (!nrst)
        word_evt && (sel == acs_pkg::SEL_RANGE) |=> range_r == $past(word_hold_r[10:3]))
        else $error("range write lost");
    chk_span_bipolar: assert property (@(posedge core_clk) disable iff (!nrst)
        ##1 span_r == ($past(range_r) & $past(bip_r) & ~$past(uni_r) & {8{!$past(pdiff_r)}}))
        else $error("span outside bipolar pair");
    chk_mask_custom: assert property (@(posedge core_clk) disable iff (!nrst)
        (mode_r == acs_pkg::mode_custom_int) || (mode_r == acs_pkg::mode_custom_scan_external_clock)
        |=> act_mask_r == $past(mask_r))
        else $error("custom mask not applied");
    chk_seq_ignore: assert property (@(posedge core_clk) disable iff (!nrst)
        nib_evt && ({1'b0, nib_idx_r} >= pend_len_r) |-> !mem_wr)
        else $error("excess nibble written");
    chk_seq_activate: assert property (@(posedge core_clk) disable iff (!nrst)
        (seq_r == acs_pkg::seq_in_pattern) && cs_fall |=> (act_len_r == $past(pend_len_r))
        && (act_cnt_r == $past(wr_cnt_r)) && (seq_r == acs_pkg::seq_idle))
        else $error("sequence not activated");
    chk_seq_fill: assert property (@(posedge core_clk) disable iff (!nrst)
        ({1'b0, seq_rd_idx} >= act_cnt_r) |=> seq_rd_chan == acs_pkg::CHANNEL_ZERO)
        else $error("unfilled entry not channel 0");
    chk_echo_load: assert property (@(posedge sclk) disable iff (!nrst)
        word_done && echo_s2_r && frame_rst_n |=> echo_sh_r == $past(word_now))
        else $error("echo word not loaded");
    chk_echo_off: assert property (@(posedge sclk) disable iff (!nrst)
        word_done && !echo_s2_r && frame_rst_n |=> echo_sh_r == 16'h0000)
        else $error("echo while disabled");
    cov_sequence: cover property (@(posedge core_clk) disable iff (!nrst)
        (seq_r == acs_pkg::seq_in_pattern) && cs_fall);
    cov_range: cover property (@(posedge core_clk) disable iff (!nrst) word_evt && (sel == acs_pkg::SEL_RANGE));
    cov_custom: cover property (@(posedge core_clk) disable iff (!nrst)
        mode_r == acs_pkg::mode_custom_scan_external_clock);
    cov_echo: cover property (@(posedge sclk) disable iff (!nrst) word_done && echo_s2_r);
endmodule
`default_nettype wire

/* shared/acs_pkg.sv */
`default_nettype none
package acs_pkg;
    // ------------------------------------------------------------
    // register selects, top five bits of each word
    // ------------------------------------------------------------
    localparam logic [4:0] SEL_SCAN_CTRL = 5'h01;
    localparam logic [4:0] SEL_CONFIG = 5'h10;
    localparam logic [4:0] SEL_UNIPOLAR = 5'h11;
    localparam logic [4:0] SEL_BIPOLAR = 5'h12;
    localparam logic [4:0] SEL_RANGE = 5'h13;
    localparam logic [4:0] SEL_CUSTOM_HI = 5'h14;
    localparam logic [4:0] SEL_CUSTOM_LO = 5'h15;
    localparam logic [4:0] SEL_SEQ_LEN = 5'h16;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SEL_MSB = 15;
    localparam int SEL_LSB = 11;
    localparam int CNT_MSB = 6;
    localparam int CNT_LSB = 5;
    localparam int PD_MSB = 4;
    localparam int PD_LSB = 3;
    localparam int ECHO_BIT = 2;
    localparam int PAIR_MSB = 10;
    localparam int PAIR_LSB = 3;
    localparam int PDIFF_BIT = 2;
    localparam int MODE_MSB = 10;
    localparam int MODE_LSB = 7;
    localparam int CHAN_MSB = 6;
    localparam int CHAN_LSB = 3;
    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [1:0] COUNT_RESET = 2'h0;
    localparam logic [7:0] PAIR_RESET = 8'h00;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [3:0] CHAN_RESET = 4'h0;
    localparam logic [8:0] LEN_RESET = 9'h000;
    localparam logic [4:0] RESULT_ONE = 5'h01;
    localparam logic [10:0] BIT_WORD_LAST = 11'h00F;
    localparam logic [10:0] BIT_CNT_MAX = 11'h7FF;
    localparam logic [3:0] CHANNEL_ZERO = 4'h0;
    localparam int SEQ_DEPTH = 256;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        pd_normal = 2'b00,
        pd_full = 2'b01,
        pd_partial = 2'b10,
        pd_unused = 2'b11
    } acs_pd_t;
    typedef enum logic [3:0] {
        mode_manual = 4'b0000,
        mode_repeat = 4'b0001,
        mode_standard_int = 4'b0010,
        mode_standard_scan_external_clock = 4'b0011,
        mode_upper_int = 4'b0100,
        mode_upper_ext = 4'b0101,
        mode_custom_int = 4'b0110,
        mode_custom_scan_external_clock = 4'b0111,
        mode_sequence = 4'b1000
    } acs_mode_t;
    typedef enum logic [1:0] {
        seq_idle = 2'b00,
        seq_wait_pattern = 2'b01,
        seq_in_pattern = 2'b10
    } acs_seq_t;
endpackage
`default_nettype wire

/* src/acs_seq_mem.sv */
`default_nettype none
module acs_seq_mem (
    // clock
    input wire logic core_clk,
    input wire logic nrst,
    // write side
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [3:0] wr_data,
    // read side
    input wire logic [7:0] rd_addr,
    input wire logic rd_zero,
    output logic [3:0] rd_data_r
);
    logic [3:0] mem [0:acs_pkg::SEQ_DEPTH-1];
    logic [3:0] rd_data_nxt;

    always_comb begin
        rd_data_nxt = rd_zero ? acs_pkg::CHANNEL_ZERO : mem[rd_addr];
    end

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_r <= acs_pkg::CHANNEL_ZERO;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end
endmodule
`default_nettype wire

/* testbench/acs_host_model.sv */
`default_nettype none
module acs_host_model (
    // link to the device
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] echo_word;
    // ----------------------------------------
    // serial master, clock parked low outside frames
    // ----------------------------------------
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b1;
        echo_word = 16'h0000;
    end
    // dout taken just before each rise, before the device moves it
    task automatic frame(input logic [63:0] bits, input int n);
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            din = bits[n - 1 - i];
            #40;
            echo_word = {echo_word[14:0], dout};
            sclk = 1'b1;
            #40;
            sclk = 1'b0;
        end
        #40;
        cs_n = 1'b1;
        din = ~din; // released line must not keep its last value
        #300;
    endtask
endmodule
`default_nettype wire

/* testbench/acs_cfg_regs_tb.sv */
`default_nettype none
module acs_cfg_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, nrst, sclk, cs_n, din, dout, pd_full, pd_partial, pdiff_common;
    logic [7:0] seq_rd_idx, pair_bipolar, pair_full_span;
    logic [3:0] seq_rd_chan, scan_mode, channel_number_field;
    logic [4:0] repeat_result_count;
    logic [15:0] channel_scan_mask, active_chan_mask;
    logic [8:0] sequence_length;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    acs_host_model host (.sclk, .cs_n, .din, .dout);
    acs_cfg_regs DUT (.core_clk, .nrst, .sclk, .cs_n, .din, .dout, .seq_rd_idx, .seq_rd_chan,
        .repeat_result_count, .pd_full, .pd_partial, .scan_mode, .channel_number_field,
        .channel_scan_mask, .active_chan_mask, .pair_bipolar, .pair_full_span, .pdiff_common,
        .sequence_length);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] sel, input logic [10:0] body);
        host.frame({48'h0, sel, body}, 16);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [3:0] exp);
        @(posedge core_clk);
        #5 seq_rd_idx = idx;
        @(posedge core_clk);
        @(posedge core_clk);
        #5 chk("seq entry", 16'(exp), 16'(seq_rd_chan));
    endtask
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // hang guard: the whole sequence needs well under 3000 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        seq_rd_idx = 8'h00;
        repeat (12) @(posedge core_clk);
        #5 nrst = 1'b1;
        repeat (4) @(posedge core_clk);
        // off the core edge, so no check races an output update
        #10;
        chk("count at reset", 16'h0001, 16'(repeat_result_count));
        chk("span at reset", 16'h0000, 16'(pair_full_span));
        wr(acs_pkg::SEL_BIPOLAR, {8'hA5, 3'h0});
        wr(acs_pkg::SEL_RANGE, {8'h3C, 3'h0});
        chk("bipolar", 16'h00A5, 16'(pair_bipolar));
        chk("span", 16'h0024, 16'(pair_full_span));
        wr(acs_pkg::SEL_UNIPOLAR, {8'h04, 3'h0});
        chk("bipolar uni", 16'h00A1, 16'(pair_bipolar));
        chk("span uni", 16'h0020, 16'(pair_full_span));
        for (int c = 0; c < 4; c++) begin
            wr(acs_pkg::SEL_CONFIG, {4'h0, 2'h0, 2'(c), 3'h0});
            chk("power down", 16'((c == 3) ? 0 : c), {14'h0, pd_partial, pd_full});
            chk("span held", 16'h0020, 16'(pair_full_span));
        end
        wr(acs_pkg::SEL_UNIPOLAR, {8'h04, 3'h4});
        chk("pdiff", 16'h0001, 16'(pdiff_common));
        chk("bipolar pdiff", 16'h0000, 16'(pair_bipolar));
        chk("span pdiff", 16'h0000, 16'(pair_full_span));
        wr(acs_pkg::SEL_SCAN_CTRL, {4'h1, 4'h5, 3'h0});
        chk("mode", 16'h0001, 16'(scan_mode));
        chk("channel", 16'h0005, 16'(channel_number_field));
        for (int c = 0; c < 4; c++) begin
            wr(acs_pkg::SEL_CONFIG, {4'h0, 2'(c), 5'h00});
            chk("result count", 16'(4 * (c + 1)), 16'(repeat_result_count));
        end
        wr(acs_pkg::SEL_SCAN_CTRL, {4'h0, 4'h5, 3'h0});
        chk("count off repeat", 16'h0001, 16'(repeat_result_count));
        wr(acs_pkg::SEL_SCAN_CTRL, {4'h3, 4'h5, 3'h0});
        chk("standard mask", 16'h003F, active_chan_mask);
        wr(acs_pkg::SEL_SCAN_CTRL, {4'h4, 4'h5, 3'h0});
        chk("upper mask", 16'hFFE0, active_chan_mask);
        wr(acs_pkg::SEL_SCAN_CTRL, {4'h8, 4'h5, 3'h0});
        chk("sequence mode", 16'h0008, 16'(scan_mode));
        chk("sequence mask", 16'h0000, active_chan_mask);
        wr(acs_pkg::SEL_CUSTOM_HI, {8'hC3, 3'h0});
        wr(acs_pkg::SEL_CUSTOM_LO, {8'h5A, 3'h0});
        wr(acs_pkg::SEL_SCAN_CTRL, {4'h6, 4'h0, 3'h0});
        chk("scan mask", 16'hC35A, channel_scan_mask);
        chk("active mask", 16'hC35A, active_chan_mask);
        wr(acs_pkg::SEL_CONFIG, 11'h004);
        wr(acs_pkg::SEL_CONFIG, 11'h064);
        chk("echo first frame", 16'h0000, host.echo_word);
        wr(acs_pkg::SEL_SCAN_CTRL, {4'h7, 4'h3, 3'h0});
        chk("echo word", 16'h8064, host.echo_word);
        chk("active mask ext", 16'hC35A, active_chan_mask);
        wr(acs_pkg::SEL_CONFIG, 11'h000);
        // the disabling word is still echoed: the enable reaches the link a frame late
        wr(acs_pkg::SEL_SCAN_CTRL, {4'h6, 4'h3, 3'h0});
        chk("echo last word", 16'h8000, host.echo_word);
        wr(acs_pkg::SEL_SCAN_CTRL, {4'h6, 4'h3, 3'h0});
        chk("echo off", 16'h0000, host.echo_word);
        wr(acs_pkg::SEL_SEQ_LEN, {8'h03, 3'h0});
        host.frame({50'h0, 4'h7, 4'hA, 4'h3, 2'b10}, 14);
        chk("length pending", 16'h0000, 16'(sequence_length));
        wr(acs_pkg::SEL_CONFIG, 11'h000);
        chk("length", 16'h0004, 16'(sequence_length));
        rd(8'h00, 4'h7);
        rd(8'h01, 4'hA);
        rd(8'h02, 4'h3);
        rd(8'h03, 4'h0);
        rd(8'h04, 4'h0);
        wr(acs_pkg::SEL_SEQ_LEN, {8'h01, 3'h0});
        host.frame({44'h0, 20'h12345}, 20);
        wr(acs_pkg::SEL_CONFIG, 11'h000);
        chk("length short", 16'h0002, 16'(sequence_length));
        rd(8'h01, 4'h2);
        rd(8'h02, 4'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
